// ---- rtl/sfl_front.sv ----
`timescale 1ns/10ps

// Summary of operation
// - Capture on rising, drive on falling edge.
// - Clock modes 0 and 3 both accepted.
// - Two-line instructions use IO0 and IO1.
// - Four-line reads use all four lines.
// - Four-line instructions need quad_lines_enable set.
// - 38h enters four-line command mode if enabled.
// - Command mode opcode takes two clocks.
// - Modes exclusive; FFh returns to SPI.
// - Power-up and 99h select SPI mode.
// - Pause only in single/two-line SPI.
// - Pause starts per clock level rule.
// - Pause ends per clock level rule.
// - Paused: output floats, inputs ignored, state kept.
// - Supply reset blocks all instructions.
// - Write instructions rejected during powerup_write_delay.
// - write_permit_latch cleared after power-up.
// - Program, erase, status write need latch.
// - Completion clears write_permit_latch unless 06h is taken in that same cycle.
// - Power-down ignores all but release.
// - Status write gated by locks, latch, pin.
// - Lock encodings: soft, pin, power, permanent.
// - 38h ignored without enable; enable kept.
module sfl_front
    import sfl_pkg::*;
#(
    parameter int PUW_CYC = PUW_TIME_US * CLK_MHZ
) (
    // System clock and supply-threshold reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Serial link from the host.
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_n,
    // Non-volatile status image.
    input  wire logic [15:0] nv_status,
    output logic             nv_wr,
    output logic      [15:0] nv_data,
    // Array engine.
    input  wire logic [7:0]  rd_fill,
    input  wire logic        op_busy,
    input  wire logic        op_done,
    output logic             op_start,
    output logic      [7:0]  op_code,
    // Status levels.
    output logic             write_permit_latch,
    output logic             four_line_command_mode,
    output logic             sleeping,
    output logic             write_lockout
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic [1:0] lsh,
                                             input logic [3:0] io);
        unique case (lsh)
            LSH_4:   shift_in = {sh[11:0], io};
            LSH_2:   shift_in = {sh[13:0], io[1:0]};
            default: shift_in = {sh[14:0], io[0]};
        endcase
    endfunction

    // Single-line data leaves on IO1, the old output pin.
    function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [1:0] lsh);
        unique case (lsh)
            LSH_4:   top_bits = b[7:4];
            LSH_2:   top_bits = {2'h0, b[7:6]};
            default: top_bits = {2'h0, b[7], 1'b0};
        endcase
    endfunction

    function automatic sfl_fmt_t dec_fmt(input logic [7:0] op, input sfl_pub_t p);
        sfl_fmt_t   f;
        logic [1:0] base;
        logic [1:0] two;
        logic [6:0] a_clk;
        base       = p.four_mode ? LSH_4 : LSH_1;
        two        = p.four_mode ? LSH_4 : LSH_2;
        a_clk      = ADDR_BITS >> base;
        f.opc_clks = p.four_mode ? OPC_CLKS_FOUR : OPC_CLKS_SPI;
        f.rd       = 1'b0;
        f.in_lsh   = base;
        f.out_lsh  = base;
        f.data_at  = f.opc_clks;
        case (op)
            OP_RDSR1, OP_RDSR2: begin
                f.rd = 1'b1;
            end
            OP_READ: begin
                f.rd      = 1'b1;
                f.data_at = 7'(f.opc_clks + a_clk);
            end
            OP_FAST: begin
                f.rd      = 1'b1;
                f.data_at = 7'(f.opc_clks + a_clk + DUMMY_FAST);
            end
            OP_DUAL_OUT: begin
                f.rd      = 1'b1;
                f.out_lsh = two;
                f.data_at = 7'(f.opc_clks + a_clk + DUMMY_FAST);
            end
            OP_DUAL_IO: begin
                f.rd      = 1'b1;
                f.in_lsh  = two;
                f.out_lsh = two;
                f.data_at = 7'(f.opc_clks + (ADDR_MODE_BITS >> two));
            end
            OP_QUAD_OUT: begin
                f.rd      = p.qle;
                f.out_lsh = LSH_4;
                f.data_at = 7'(f.opc_clks + a_clk + DUMMY_FAST);
            end
            OP_QUAD_IO, OP_QUAD_WORD: begin
                f.rd      = p.qle;
                f.in_lsh  = LSH_4;
                f.out_lsh = LSH_4;
                f.data_at = 7'(f.opc_clks + (ADDR_MODE_BITS >> LSH_4)
                               + ((op == OP_QUAD_IO) ? DUMMY_QIO : DUMMY_QWORD));
            end
            default: begin
                f.rd = 1'b0;
            end
        endcase
        if (!p.ready || p.sleep) begin
            f.rd = 1'b0;
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    sfl_pub_t   pub_r;
    sfl_pub_t   pub_nxt;
    sfl_frame_t frm_r;
    sfl_fmt_t   fmt_w;
    sfl_sys_t   st_r;
    sfl_sys_t   st_nxt;
    logic [6:0]  cnt_r;
    logic        acc_r;
    logic        tog_r;
    logic        lclr_r;
    logic [7:0]  osh_r;
    logic [3:0]  obit_r;
    logic [3:0]  io_o_r;
    logic [3:0]  oe_n_r;
    logic        cs_m_r;
    logic        cs_s_r;
    logic        cs_d_r;
    logic        tg_m_r;
    logic        tg_s_r;
    logic        tg_seen_r;
    logic        wg_m_r;
    logic        wg_s_r;
    logic [31:0] puw_cnt_r;
    logic        wpl_r;
    logic        wpl_nxt;
    logic        four_r;
    logic        four_nxt;
    logic        sleep_r;
    logic        sleep_nxt;
    logic [7:0]  sr1_r;
    logic [7:0]  sr2_r;
    logic        op_start_r;
    logic [7:0]  op_code_r;
    logic        nv_wr_r;
    logic [15:0] nv_data_r;
    logic        lockout_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Link side, on the host's serial clock. Select high clears the clock count and the output state.

    wire        paused_w  = ~pub_r.qle & ~io_i[3];
    wire [1:0]  opc_lsh_w = pub_r.four_mode ? LSH_4 : LSH_1;
    wire [15:0] opc_sh_w  = shift_in({8'h00, frm_r.opcode}, opc_lsh_w, io_i);
    wire [15:0] dat_sh_w  = shift_in(frm_r.data, fmt_w.in_lsh, io_i);
    wire        in_opc_w  = cnt_r < fmt_w.opc_clks;
    wire        ok_w      = 7'(cnt_r + 7'h01) >= fmt_w.opc_clks;
    wire [4:0]  dstep_w   = 5'h01 << fmt_w.in_lsh;
    wire [4:0]  dsum_w    = 5'((cnt_r == 7'h00) ? 5'h00 : frm_r.dbits) + dstep_w;
    wire        dovf_w    = frm_r.dbits > 5'(DBITS_MAX - dstep_w);
    wire        drive_w   = fmt_w.rd & frm_r.ok & (cnt_r >= fmt_w.data_at);
    wire        load_w    = (cnt_r == fmt_w.data_at) | (obit_r == 4'h0);
    wire [3:0]  ostep_w   = 4'h1 << fmt_w.out_lsh;
    wire [3:0]  mask_w    = top_bits(8'hff, fmt_w.out_lsh);
    wire [7:0]  src_w     = (frm_r.opcode == OP_RDSR1) ? pub_r.sr1 :
                            (frm_r.opcode == OP_RDSR2) ? pub_r.sr2 : pub_r.fill;
    wire [7:0]  obyte_w   = load_w ? src_w : osh_r;

    assign fmt_w = dec_fmt(frm_r.opcode, pub_r);

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt_r <= 7'h00;
            acc_r <= 1'b0;
        end else begin
            acc_r <= ~paused_w;
            if (!paused_w && cnt_r != CNT_MAX) begin
                cnt_r <= 7'(cnt_r + 7'h01);
            end
        end
    end

    always_ff @(posedge sck or posedge lclr_r) begin
        if (lclr_r) begin
            tog_r <= 1'b0;
        end else if (!cs_n && !paused_w && cnt_r == 7'h00) begin
            tog_r <= ~tog_r;
        end
    end

    // Frame contents outlive the frame so the system side can read them after select rises.
    always_ff @(posedge sck) begin
        if (!cs_n && !paused_w) begin
            frm_r.ok <= ok_w;
            if (in_opc_w) begin
                frm_r.opcode <= opc_sh_w[7:0];
                frm_r.dbits  <= 5'h00;
            end else begin
                frm_r.data  <= dat_sh_w;
                frm_r.dbits <= dovf_w ? DBITS_MAX : dsum_w;
            end
        end
    end

    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            oe_n_r <= 4'hf;
            io_o_r <= 4'h0;
            osh_r  <= 8'h00;
            obit_r <= 4'h0;
        end else begin
            oe_n_r <= (drive_w && !paused_w) ? ~mask_w : 4'hf;
            if (acc_r && drive_w) begin
                io_o_r <= top_bits(obyte_w, fmt_w.out_lsh);
                osh_r  <= 8'(obyte_w << ostep_w);
                obit_r <= 4'((load_w ? OBITS_BYTE : obit_r) - ostep_w);
            end
        end
    end

    assign io_o    = io_o_r;
    assign io_oe_n = oe_n_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock.

    always_ff @(posedge clk) begin
        cs_m_r <= cs_n;
        cs_s_r <= cs_m_r;
        cs_d_r <= cs_s_r;
        tg_m_r <= tog_r;
        tg_s_r <= tg_m_r;
        wg_m_r <= io_i[2];
        wg_s_r <= wg_m_r;
    end

    // A frame is taken when select rises after at least a whole opcode.
    wire       frame_w  = cs_s_r & ~cs_d_r & (tg_s_r != tg_seen_r) & frm_r.ok;
    wire [7:0] op_w     = frm_r.opcode;
    wire       gate_w   = frame_w & (st_r != SYS_RESET)
                          & (~sleep_r | (op_w == OP_WAKE));
    wire       wr_ok_w  = st_r == SYS_RUN;
    wire [1:0] lock_w   = {sr2_r[SR2_LOCK_HI], sr1_r[SR1_LOCK_LO]};
    wire       sr_open_w = wpl_r & ((lock_w == LOCK_SW)
                           | ((lock_w == LOCK_PIN) & (sr2_r[SR2_QLE] | wg_s_r)));
    wire       is_arr_w = (op_w == OP_PROG) | (op_w == OP_ERASE_4K) | (op_w == OP_ERASE_64K)
                          | (op_w == OP_ERASE_ALL) | (op_w == OP_ERASE_ALT);
    wire       set_wpl_w = gate_w & (op_w == OP_WREN) & wr_ok_w;
    wire       do_wsr_w = gate_w & (op_w == OP_WRSR) & wr_ok_w & sr_open_w
                          & (frm_r.dbits >= BYTE_BITS);
    wire       do_arr_w = gate_w & is_arr_w & wr_ok_w & wpl_r;
    wire       clr_wpl_w = (gate_w & ((op_w == OP_WRDI) | (op_w == OP_SOFT_RST)))
                          | do_wsr_w | op_done;
    wire       two_b_w  = frm_r.dbits >= WORD_BITS;
    wire [7:0] wb1_w    = two_b_w ? frm_r.data[15:8] : frm_r.data[7:0];
    wire [7:0] wb2_w    = two_b_w ? frm_r.data[7:0] : sr2_r;
    wire       keep_q_w = four_r & sr2_r[SR2_QLE];
    wire [7:0] new_sr1_w = {wb1_w[7:2], sr1_r[1:0]};
    wire [7:0] new_sr2_w = {wb2_w[7:2], wb2_w[SR2_QLE] | keep_q_w, wb2_w[SR2_LOCK_HI]};
    wire       puw_end_w = puw_cnt_r == 32'(PUW_CYC - 1);
    wire       pwr_lock_w = {nv_status[8 + SR2_LOCK_HI], nv_status[SR1_LOCK_LO]} == LOCK_PWR;

    ////////////////////////////////////////////////////////////////////////////////
    // System state and next values.

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            SYS_RESET:   st_nxt = SYS_LOCKOUT;
            SYS_LOCKOUT: st_nxt = puw_end_w ? SYS_RUN : SYS_LOCKOUT;
            SYS_RUN:     st_nxt = SYS_RUN;
        endcase
        if (sys_rst) begin
            st_nxt = SYS_RESET;
        end
    end

    assign wpl_nxt   = set_wpl_w ? 1'b1 : clr_wpl_w ? 1'b0 : wpl_r;
    assign four_nxt  = (gate_w & (op_w == OP_FOUR_ON) & sr2_r[SR2_QLE]) ? 1'b1 :
                       (gate_w & ((op_w == OP_FOUR_OFF) | (op_w == OP_SOFT_RST))) ? 1'b0 : four_r;
    assign sleep_nxt = (gate_w & (op_w == OP_SLEEP)) ? 1'b1 :
                       (gate_w & (op_w == OP_WAKE)) ? 1'b0 : sleep_r;

    always_comb begin
        pub_nxt           = pub_r;
        pub_nxt.ready     = st_r != SYS_RESET;
        pub_nxt.four_mode = four_r;
        pub_nxt.qle       = sr2_r[SR2_QLE];
        pub_nxt.sleep     = sleep_r;
        pub_nxt.sr1       = {sr1_r[7:2], wpl_r, op_busy};
        pub_nxt.sr2       = sr2_r;
        pub_nxt.fill      = rd_fill;
    end

    always_ff @(posedge clk) begin
        st_r   <= st_nxt;
        lclr_r <= st_nxt == SYS_RESET;
        if (cs_s_r && cs_d_r) begin
            pub_r <= pub_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            puw_cnt_r <= 32'h0;
            tg_seen_r <= tg_s_r;
            wpl_r     <= 1'b0;
            four_r    <= 1'b0;
            sleep_r   <= 1'b0;
            lockout_r <= 1'b1;
        end else begin
            puw_cnt_r <= (st_r == SYS_LOCKOUT) ? 32'(puw_cnt_r + 32'h1) : 32'h0;
            tg_seen_r <= frame_w ? tg_s_r : tg_seen_r;
            wpl_r     <= wpl_nxt;
            four_r    <= four_nxt;
            sleep_r   <= sleep_nxt;
            lockout_r <= st_nxt != SYS_RUN;
        end
    end

    // The status image is loaded while reset holds; a power-cycle lock falls back to software.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sr1_r <= nv_status[7:0];
            sr2_r <= nv_status[15:8];
            if (pwr_lock_w) begin
                sr1_r[SR1_LOCK_LO] <= 1'b0;
                sr2_r[SR2_LOCK_HI] <= 1'b0;
            end
        end else if (do_wsr_w) begin
            sr1_r <= new_sr1_w;
            sr2_r <= new_sr2_w;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_start_r <= 1'b0;
            op_code_r  <= 8'h00;
            nv_wr_r    <= 1'b0;
            nv_data_r  <= 16'h0000;
        end else begin
            op_start_r <= do_arr_w;
            op_code_r  <= do_arr_w ? op_w : op_code_r;
            nv_wr_r    <= do_wsr_w;
            nv_data_r  <= do_wsr_w ? {new_sr2_w, new_sr1_w} : nv_data_r;
        end
    end

    assign op_start               = op_start_r;
    assign op_code                = op_code_r;
    assign nv_wr                  = nv_wr_r;
    assign nv_data                = nv_data_r;
    assign write_permit_latch     = wpl_r;
    assign four_line_command_mode = four_r;
    assign sleeping               = sleep_r;
    assign write_lockout          = lockout_r;

endmodule

// ---- rtl/sfl_pkg.sv ----
package sfl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction codes.
    localparam logic [7:0] OP_WREN       = 8'h06;
    localparam logic [7:0] OP_WRDI       = 8'h04;
    localparam logic [7:0] OP_WRSR       = 8'h01;
    localparam logic [7:0] OP_RDSR1      = 8'h05;
    localparam logic [7:0] OP_RDSR2      = 8'h35;
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_FAST       = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
    localparam logic [7:0] OP_QUAD_OUT   = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO    = 8'heb;
    localparam logic [7:0] OP_QUAD_WORD  = 8'he7;
    localparam logic [7:0] OP_PROG       = 8'h02;
    localparam logic [7:0] OP_ERASE_4K   = 8'h20;
    localparam logic [7:0] OP_ERASE_64K  = 8'hd8;
    localparam logic [7:0] OP_ERASE_ALL  = 8'hc7;
    localparam logic [7:0] OP_ERASE_ALT  = 8'h60;
    localparam logic [7:0] OP_FOUR_ON    = 8'h38;
    localparam logic [7:0] OP_FOUR_OFF   = 8'hff;
    localparam logic [7:0] OP_SOFT_RST   = 8'h99;
    localparam logic [7:0] OP_SLEEP      = 8'hb9;
    localparam logic [7:0] OP_WAKE       = 8'hab;

    ////////////////////////////////////////////////////////////////////////////////
    // Lane shifts (log2 of lanes) and phase lengths in serial clocks or bits.
    localparam logic [1:0] LSH_1         = 2'h0;
    localparam logic [1:0] LSH_2         = 2'h1;
    localparam logic [1:0] LSH_4         = 2'h2;
    localparam logic [6:0] OPC_CLKS_SPI  = 7'h08;
    localparam logic [6:0] OPC_CLKS_FOUR = 7'h02;
    localparam logic [6:0] ADDR_BITS     = 7'h18;
    localparam logic [6:0] ADDR_MODE_BITS = 7'h20;
    localparam logic [6:0] DUMMY_FAST    = 7'h08;
    localparam logic [6:0] DUMMY_QIO     = 7'h04;
    localparam logic [6:0] DUMMY_QWORD   = 7'h02;
    localparam logic [6:0] CNT_MAX       = 7'h7f;
    localparam logic [4:0] DBITS_MAX     = 5'h1f;
    localparam logic [4:0] BYTE_BITS     = 5'h08;
    localparam logic [4:0] WORD_BITS     = 5'h10;
    localparam logic [3:0] OBITS_BYTE    = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Status bit positions and lock encodings.
    localparam int SR1_BUSY     = 0;
    localparam int SR1_WPL      = 1;
    localparam int SR1_LOCK_LO  = 7;
    localparam int SR2_LOCK_HI  = 0;
    localparam int SR2_QLE      = 1;
    localparam logic [1:0] LOCK_SW  = 2'h0;
    localparam logic [1:0] LOCK_PIN = 2'h1;
    localparam logic [1:0] LOCK_PWR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_MHZ          = 100;
    localparam int PUW_TIME_US      = 1000;

    typedef enum logic [2:0] {
        SYS_RESET   = 3'b001,
        SYS_LOCKOUT = 3'b010,
        SYS_RUN     = 3'b100
    } sfl_sys_t;

    typedef struct packed {
        logic       ready;
        logic       four_mode;
        logic       qle;
        logic       sleep;
        logic [7:0] sr1;
        logic [7:0] sr2;
        logic [7:0] fill;
    } sfl_pub_t;

    typedef struct packed {
        logic       rd;
        logic [1:0] in_lsh;
        logic [1:0] out_lsh;
        logic [6:0] data_at;
        logic [6:0] opc_clks;
    } sfl_fmt_t;

    typedef struct packed {
        logic        ok;
        logic [7:0]  opcode;
        logic [15:0] data;
        logic [4:0]  dbits;
    } sfl_frame_t;

endpackage

// ---- tb/sfl_front_monitor.sv ----
`timescale 1ns/10ps
module sfl_front_mon
    import sfl_pkg::*;
(
    // Clock, reset and link.
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cs_n,
    input wire logic [3:0]  io_oe_n,
    // System side.
    input wire logic [15:0] nv_status,
    input wire logic        nv_wr,
    input wire logic [15:0] nv_data,
    input wire logic        op_done,
    input wire logic        op_start,
    input wire logic        write_permit_latch,
    input wire logic        four_line_command_mode,
    input wire logic        sleeping,
    input wire logic        write_lockout
);
    // Quad enable as the block last loaded or wrote it.
    logic qle_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            qle_r <= nv_status[8 + SR2_QLE];
        end else if (nv_wr) begin
            qle_r <= nv_data[8 + SR2_QLE];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_reset_state: assert property (
        $fell(sys_rst) |-> write_lockout && !write_permit_latch && !four_line_command_mode)
        else $error("state not cleared by reset");
    chk_reset_quiet: assert property (
        $fell(sys_rst) |-> !op_start && !nv_wr && !sleeping)
        else $error("activity straight out of reset");
    chk_lockout_gate: assert property (
        $rose(write_permit_latch) |-> $past(!write_lockout) && $past(!sleeping))
        else $error("latch set during lockout");
    chk_start_gated: assert property (
        op_start |-> $past(write_permit_latch) && $past(!write_lockout))
        else $error("operation started without latch");
    chk_done_clears: assert property (
        op_done |=> !write_permit_latch)
        else $error("latch kept after completion");
    chk_swr_clears: assert property (
        nv_wr |-> ##[0:1] !write_permit_latch)
        else $error("latch kept after status write");
    chk_idle_float: assert property (
        cs_n |-> io_oe_n == 4'hf)
        else $error("pins driven while deselected");
    chk_quad_gate: assert property (
        $rose(four_line_command_mode) |-> qle_r)
        else $error("command mode without enable");
    chk_sleep_block: assert property (
        sleeping && $past(sleeping) |-> !op_start && !nv_wr && !$rose(write_permit_latch))
        else $error("instruction taken while asleep");

    cover property (op_start);
    cover property ($rose(four_line_command_mode));
    cover property ($rose(sleeping));
endmodule

bind sfl_front sfl_front_mon mon (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .io_oe_n(io_oe_n),
    .nv_status(nv_status), .nv_wr(nv_wr), .nv_data(nv_data), .op_done(op_done), .op_start(op_start),
    .write_permit_latch(write_permit_latch), .four_line_command_mode(four_line_command_mode),
    .sleeping(sleeping), .write_lockout(write_lockout));

// ---- tb/sfl_host.sv ----
`timescale 1ns/10ps
module sfl_host (
    // Link pins driven by the host.
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] drv,
    output logic [3:0] drv_en,
    // Resolved pin levels.
    input  wire logic [3:0] io
);
    logic wp_lvl;

    initial begin
        sck = 1'b0;
        drv = 4'hf;
        drv_en = 4'hd;
        wp_lvl = 1'b1;
        // Select rises after time zero so the link logic sees a clean clearing edge.
        #1 cs_n = 1'b1;
    end

    // Sends an opcode and wb write bits, then samples rb clocks of read data.
    task automatic frame(input logic [7:0] op, input logic q, input logic m3, input int wb,
                         input logic [15:0] wd, input int rb, output logic [7:0] rd);
        logic [23:0] sh;
        int          n;
        sh = {op, wd};
        n = q ? 2 + wb / 4 : 8 + wb;
        rd = 8'h00;
        sck = m3;
        drv_en = q ? 4'hf : 4'hd;
        drv = {1'b1, wp_lvl, 2'b11};
        // Select edges are kept off the rising system clock edges.
        #13 cs_n = 1'b0;
        #40;
        for (int i = 0; i < n + rb; i++) begin
            sck = 1'b0;
            if (i == n) drv_en = q ? 4'h0 : 4'hc;
            if (i < n && q) drv = sh[23:20];
            if (i < n && !q) drv[0] = sh[23];
            sh = q ? sh << 4 : sh << 1;
            #16 sck = 1'b1;
            if (i >= n) rd = q ? {rd[3:0], io} : {rd[6:0], io[1]};
            #16;
        end
        sck = m3;
        #40 cs_n = 1'b1;
        drv_en = 4'hd;
        #70;
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
    import sfl_pkg::*;
    logic        clk, sys_rst, sck, cs_n, op_busy, op_done, op_start, nv_wr;
    logic        tgl = 1'b0;
    logic        write_permit_latch, four_line_command_mode, sleeping, write_lockout;
    logic [3:0]  io_i, io_o, io_oe_n, drv, drv_en;
    logic [7:0]  rd_fill, op_code;
    logic [15:0] nv_status, nv_data;
    logic [15:0] last_wr = 16'h0000;
    int          err_count, checked;
    int          starts = 0;
    int          writes = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Released lines show a toggling pattern rather than a held value.
    assign io_i = (~io_oe_n & io_o) | (io_oe_n & drv_en & drv) | (io_oe_n & ~drv_en & {4{tgl}});

    always @(posedge clk) begin
        tgl <= ~tgl;
        if (op_start === 1'b1) starts <= starts + 1;
        if (nv_wr === 1'b1) writes <= writes + 1;
        if (nv_wr === 1'b1) last_wr <= nv_data;
    end

    sfl_front #(.PUW_CYC(200)) dut (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
        .io_i(io_i), .io_o(io_o), .io_oe_n(io_oe_n), .nv_status(nv_status), .nv_wr(nv_wr),
        .nv_data(nv_data), .rd_fill(rd_fill), .op_busy(op_busy), .op_done(op_done),
        .op_start(op_start), .op_code(op_code), .write_permit_latch(write_permit_latch),
        .four_line_command_mode(four_line_command_mode), .sleeping(sleeping),
        .write_lockout(write_lockout));
    sfl_host host (.sck(sck), .cs_n(cs_n), .drv(drv), .drv_en(drv_en), .io(io_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic q, input int wb, input logic [15:0] wd);
        logic [7:0] d;
        host.frame(op, q, 1'b0, wb, wd, 0, d);
        repeat (8) @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] op, input logic m3, input logic [7:0] exp);
        logic [7:0] d;
        host.frame(op, 1'b0, m3, 0, 16'h0000, 8, d);
        chk({8'h00, d}, {8'h00, exp});
        repeat (8) @(posedge clk);
    endtask

    task automatic done_pulse;
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial begin
        logic [7:0] ers [4];
        logic [7:0] qd;
        ers = '{OP_ERASE_4K, OP_ERASE_64K, OP_ERASE_ALL, OP_ERASE_ALT};
        {sys_rst, op_busy, op_done} = 3'h4;
        {nv_status, rd_fill} = {16'h023c, 8'h5a};
        {err_count, checked} = '0;
        repeat (8) @(posedge clk);
        chk(16'(write_lockout), 16'h0001);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        chk(16'({write_lockout, write_permit_latch, four_line_command_mode}), 16'h0004);
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        chk(16'(write_permit_latch), 16'h0000);
        rd_chk(OP_RDSR1, 1'b0, 8'h3c);
        rd_chk(OP_RDSR1, 1'b1, 8'h3c);
        rd_chk(OP_RDSR2, 1'b0, 8'h02);
        repeat (30) @(posedge clk);
        chk(16'(write_lockout), 16'h0000);
        cmd(OP_PROG, 1'b0, 0, 16'h0000);
        chk(16'(starts), 16'h0000);
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        rd_chk(OP_RDSR1, 1'b0, 8'h3e);
        cmd(OP_PROG, 1'b0, 0, 16'h0000);
        chk({8'h00, op_code}, 16'h0002);
        done_pulse();
        chk(16'(write_permit_latch), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            cmd(OP_WREN, 1'b0, 0, 16'h0000);
            cmd(ers[i], 1'b0, 0, 16'h0000);
            chk({8'h00, op_code}, {8'h00, ers[i]});
            done_pulse();
        end
        chk(16'(starts), 16'h0005);
        cmd(OP_FOUR_ON, 1'b0, 0, 16'h0000);
        chk(16'(four_line_command_mode), 16'h0001);
        host.frame(OP_RDSR1, 1'b1, 1'b0, 0, 16'h0000, 2, qd);
        chk({8'h00, qd}, 16'h003c);
        repeat (2) @(posedge clk);
        cmd(OP_SOFT_RST, 1'b1, 0, 16'h0000);
        chk(16'(four_line_command_mode), 16'h0000);
        cmd(OP_FOUR_ON, 1'b0, 0, 16'h0000);
        cmd(OP_FOUR_OFF, 1'b1, 0, 16'h0000);
        chk(16'(four_line_command_mode), 16'h0000);
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        cmd(OP_WRSR, 1'b0, 8, 16'hb400);
        chk(last_wr, 16'h02b4);
        chk(16'(write_permit_latch), 16'h0000);
        // With quad enable set the guard pin is a data lane, so clear it first.
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        cmd(OP_WRSR, 1'b0, 16, 16'hb400);
        chk(last_wr, 16'h00b4);
        host.wp_lvl = 1'b0;
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        cmd(OP_WRSR, 1'b0, 8, 16'h3400);
        chk(16'(writes), 16'h0002);
        host.wp_lvl = 1'b1;
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        cmd(OP_WRSR, 1'b0, 16, 16'h3400);
        chk(last_wr, 16'h0034);
        cmd(OP_FOUR_ON, 1'b0, 0, 16'h0000);
        chk(16'(four_line_command_mode), 16'h0000);
        cmd(OP_SLEEP, 1'b0, 0, 16'h0000);
        cmd(OP_WREN, 1'b0, 0, 16'h0000);
        chk(16'({sleeping, write_permit_latch}), 16'h0002);
        cmd(OP_WAKE, 1'b0, 0, 16'h0000);
        chk(16'(sleeping), 16'h0000);
        end_of_test();
    end
endmodule
